// >>> core/crc_consts.vh
/*
  Constants of the clock and reset control block: register addresses,
  field positions, reset values and timing figures.
  Assumes a 200 MHz core clock; counts are derived in the modules.
*/
`ifndef CRC_CONSTS_VH
`define CRC_CONSTS_VH

// ----------------------------------------------------------------
// register addresses on the i/o port
// ----------------------------------------------------------------
`define CRC_ADDR_WDCLR 8'h26
`define CRC_ADDR_CFG 8'hF8
`define CRC_ADDR_PSC 8'hFF

// ----------------------------------------------------------------
// clock configuration fields
// ----------------------------------------------------------------
`define CRC_CFG_EXT_EN 0
`define CRC_CFG_CLKOUT_DIS 1
`define CRC_CFG_PRECISION 2
`define CRC_CFG_LVR_DIS 3
`define CRC_CFG_RESUME_DLY 7
`define CRC_CFG_RESET 8'h00

// ----------------------------------------------------------------
// processor status and control: reset cause fields
// ----------------------------------------------------------------
`define CRC_PSC_LVR 4
`define CRC_PSC_WDR 6

// ----------------------------------------------------------------
// reset targets
// ----------------------------------------------------------------
`define CRC_RESET_PC 16'h0000
`define CRC_RESET_SP 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CRC_CLK_MHZ 24'hC8
`define CRC_US_PER_MS 24'h3E8
`define CRC_EXT_SHORT_US 24'h80
`define CRC_EXT_LONG_MS 24'h4
`define CRC_WDR_HOLD_MS 24'h2
`define CRC_START_US 24'h3E8
`define CRC_WATCH_MS 24'h8
`define CRC_CNT_W 24

`endif

// >>> core/crc_watchdog.v
/*
  Watchdog timer: counts core clocks while enabled and pulses on
  rollover. Assumes the clear pulse comes from the register port
  on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "crc_consts.vh"

module crc_watchdog #(
  parameter [`CRC_CNT_W-1:0] WATCH_CYC = `CRC_CNT_W'd1600000
)
(
  // clock and reset
  input wire core_clk,
  input wire resetn,
  // control
  input wire enable,
  input wire clear,
  // event
  output reg rollover
);

  reg [`CRC_CNT_W-1:0] count;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      count <= {`CRC_CNT_W{1'b0}};
      rollover <= 1'b0;
    end
    else
    begin
      rollover <= 1'b0;
      // stopped timer restarts from zero so each run gets a full period
      if (clear || !enable)
      begin
        count <= {`CRC_CNT_W{1'b0}};
      end
      else if (count == WATCH_CYC - `CRC_CNT_W'd1)
      begin
        count <= {`CRC_CNT_W{1'b0}};
        rollover <= 1'b1;
      end
      else
      begin
        count <= count + `CRC_CNT_W'd1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> core/crc_clock_reset.v
/*
  Clock source selection and reset sequencing: configuration and
  watchdog clear registers, reset cause flags, start-up, external
  oscillator switch, watchdog hold and suspend clock choice.
  Assumes supply detectors, oscillator stability and pins arrive
  asynchronously; i/o strobes come from the core on core_clk.
*/
//
// Contract
// - precision trim only internal, after usb traffic
// - clock output disable drives output pin high
// - setting ext enable halts cpu, starts resonator
// - clearing ext enable only matters at wake
// - internal mode: input pin pulled down, readable
// - power-up runs internal, clock driven out
// - external switch: wait stable, then resume delay
// - external mode left only by suspend wake or by brown-out or low-voltage reset
// - record low-voltage and watchdog reset causes
// - reset starts at zero, nothing pushed
// - reset clears registers, pins high impedance
// - brown-out forces internal mode, start-up wait
// - watchdog keeps clock mode, clears enable bit
// - both stack pointers reset to zero
// - low-voltage reset armed, start-up timed, repeats
// - low-voltage reset off by bit or suspend
// - brown-out re-arms low-voltage reset, waits supply
// - watchdog clear write restarts timer, rollover resets
// - watchdog reset holds fixed period, restarts
`timescale 1ns/1ps
`default_nettype none
`include "crc_consts.vh"

module crc_clock_reset #(
  parameter [`CRC_CNT_W-1:0] EXT_SHORT_CYC =
    `CRC_EXT_SHORT_US * `CRC_CLK_MHZ,
  parameter [`CRC_CNT_W-1:0] EXT_LONG_CYC =
    `CRC_EXT_LONG_MS * `CRC_US_PER_MS * `CRC_CLK_MHZ,
  parameter [`CRC_CNT_W-1:0] WDR_HOLD_CYC =
    `CRC_WDR_HOLD_MS * `CRC_US_PER_MS * `CRC_CLK_MHZ,
  parameter [`CRC_CNT_W-1:0] START_CYC =
    `CRC_START_US * `CRC_CLK_MHZ,
  parameter [`CRC_CNT_W-1:0] WATCH_CYC =
    `CRC_WATCH_MS * `CRC_US_PER_MS * `CRC_CLK_MHZ
)
(
  // clock and reset
  input wire core_clk,
  input wire resetn,
  // i/o register port
  input wire [7:0] ioAddr,
  input wire [7:0] ioWrData,
  input wire ioWr,
  input wire ioRd,
  output reg [7:0] ioRdData,
  // supply detectors and events
  input wire lowVoltDetect,
  input wire brownOutDetect,
  input wire usbTrafficSeen,
  input wire suspendReq,
  input wire wakeEvent,
  // oscillators
  input wire intOscClk,
  input wire extClkStable,
  output reg intOscEnable,
  output reg extOscEnable,
  output reg chipClkEnable,
  output reg clkUseExt,
  output reg trimEnable,
  output reg precisionLocked,
  // oscillator pins
  input wire oscInputPin,
  output reg oscOutputPin,
  output reg oscOutputPinOeN,
  output reg oscInputPullDown,
  output reg auxPortBitOne,
  // reset outputs to the rest of the chip
  output reg chipRstn,
  output reg cpuHalt,
  output reg pinsHighZ,
  output reg lvrActive,
  output reg [15:0] resetVector,
  output reg resetNoPush,
  output reg [7:0] stackPtrInit,
  output reg [7:0] dataStackInit,
  output reg lvrCause,
  output reg wdrCause
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [5:0] S_START = 6'h01;
  localparam [5:0] S_RUN = 6'h02;
  localparam [5:0] S_EXTWAIT = 6'h04;
  localparam [5:0] S_EXTDLY = 6'h08;
  localparam [5:0] S_WDHOLD = 6'h10;
  localparam [5:0] S_SUSP = 6'h20;

  function [`CRC_CNT_W-1:0] resumeCycles;
    input longDelay;
    begin
      resumeCycles = longDelay ? EXT_LONG_CYC - `CRC_CNT_W'd1 :
                                 EXT_SHORT_CYC - `CRC_CNT_W'd1;
    end
  endfunction

  reg [5:0] state;
  reg [`CRC_CNT_W-1:0] cnt;
  reg [7:0] cfg;
  reg useExt;
  reg [1:0] lowVoltSync, brownSync, stableSync, intClkSync, oscInSync;
  wire lowVolt, brownOut, extStable, lvrArmed;
  wire cfgWrite, pscWrite, wdClear, wdRoll;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      lowVoltSync <= 2'h0;
      brownSync <= 2'h0;
      stableSync <= 2'h0;
      intClkSync <= 2'h0;
      oscInSync <= 2'h0;
    end
    else
    begin
      lowVoltSync <= {lowVoltSync[0], lowVoltDetect};
      brownSync <= {brownSync[0], brownOutDetect};
      stableSync <= {stableSync[0], extClkStable};
      intClkSync <= {intClkSync[0], intOscClk};
      oscInSync <= {oscInSync[0], oscInputPin};
    end
  end

  assign lowVolt = lowVoltSync[1];
  assign brownOut = brownSync[1];
  assign extStable = stableSync[1];
  // detector is off when disabled by firmware or in suspend
  assign lvrArmed = !cfg[`CRC_CFG_LVR_DIS] && (state != S_SUSP);
  assign cfgWrite = ioWr && (ioAddr == `CRC_ADDR_CFG) && (state == S_RUN);
  assign pscWrite = ioWr && (ioAddr == `CRC_ADDR_PSC) && (state == S_RUN);
  assign wdClear = ioWr && (ioAddr == `CRC_ADDR_WDCLR);

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  crc_watchdog #(
    .WATCH_CYC(WATCH_CYC)
  ) uWatchdog (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(state == S_RUN),
    .clear(wdClear),
    .rollover(wdRoll)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      // power-up: internal clock, low-voltage reset armed
      state <= S_START;
      cnt <= START_CYC - `CRC_CNT_W'd1;
      cfg <= `CRC_CFG_RESET;
      useExt <= 1'b0;
      lvrCause <= 1'b1;
      wdrCause <= 1'b0;
    end
    else if (brownOut || (lowVolt && lvrArmed))
    begin
      // brown-out clears the disable bit, which re-arms the detector
      state <= S_START;
      cnt <= START_CYC - `CRC_CNT_W'd1;
      cfg <= `CRC_CFG_RESET;
      useExt <= 1'b0;
      lvrCause <= 1'b1;
    end
    else if (wdRoll)
    begin
      // clock mode kept; cleared enable bit only counts at next wake
      state <= S_WDHOLD;
      cnt <= WDR_HOLD_CYC - `CRC_CNT_W'd1;
      cfg <= `CRC_CFG_RESET;
      wdrCause <= 1'b1;
    end
    else
    begin
      // cause flags: firmware clears by writing zero; sets win above
      if (pscWrite)
      begin
        lvrCause <= lvrCause && ioWrData[`CRC_PSC_LVR];
        wdrCause <= wdrCause && ioWrData[`CRC_PSC_WDR];
      end
      case (state)
        S_START:
        begin
          // held while supply stays low, then start-up period
          if (lowVolt)
          begin
            cnt <= START_CYC - `CRC_CNT_W'd1;
          end
          else if (cnt == {`CRC_CNT_W{1'b0}})
          begin
            state <= S_RUN;
          end
          else
          begin
            cnt <= cnt - `CRC_CNT_W'd1;
          end
        end
        S_RUN:
        begin
          if (cfgWrite)
          begin
            cfg <= ioWrData;
            if (ioWrData[`CRC_CFG_EXT_EN] && !useExt)
            begin
              useExt <= 1'b1;
              state <= S_EXTWAIT;
            end
          end
          else if (suspendReq)
          begin
            state <= S_SUSP;
          end
        end
        S_EXTWAIT:
        begin
          if (extStable)
          begin
            state <= S_EXTDLY;
            cnt <= resumeCycles(cfg[`CRC_CFG_RESUME_DLY]);
          end
        end
        S_EXTDLY, S_WDHOLD:
        begin
          if (cnt == {`CRC_CNT_W{1'b0}})
          begin
            state <= S_RUN;
          end
          else
          begin
            cnt <= cnt - `CRC_CNT_W'd1;
          end
        end
        S_SUSP:
        begin
          if (wakeEvent)
          begin
            // only here does a cleared enable bit take effect
            useExt <= cfg[`CRC_CFG_EXT_EN];
            state <= cfg[`CRC_CFG_EXT_EN] ? S_EXTWAIT : S_RUN;
          end
        end
        default:
        begin
          state <= S_START;
          cnt <= START_CYC - `CRC_CNT_W'd1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ioRdData <= 8'h00;
    end
    else if (ioRd)
    begin
      case (ioAddr)
        `CRC_ADDR_CFG:
        begin
          ioRdData <= cfg;
        end
        `CRC_ADDR_PSC:
        begin
          ioRdData <= {1'b0, wdrCause, 1'b0, lvrCause, 4'h0};
        end
        default:
        begin
          // clear register is write-only and reads as zero
          ioRdData <= 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clock and pin outputs
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      intOscEnable <= 1'b1;
      extOscEnable <= 1'b0;
      chipClkEnable <= 1'b0;
      clkUseExt <= 1'b0;
      trimEnable <= 1'b0;
      precisionLocked <= 1'b0;
      oscOutputPin <= 1'b0;
      oscOutputPinOeN <= 1'b0;
      oscInputPullDown <= 1'b1;
      auxPortBitOne <= 1'b0;
    end
    else
    begin
      intOscEnable <= !useExt && (state != S_SUSP);
      extOscEnable <= useExt && (state != S_SUSP);
      // chip clocks stay off until the resonator is stable
      chipClkEnable <= (state != S_EXTWAIT) && (state != S_SUSP);
      clkUseExt <= useExt;
      trimEnable <= !useExt && cfg[`CRC_CFG_PRECISION];
      precisionLocked <= !useExt && cfg[`CRC_CFG_PRECISION] &&
        (precisionLocked || usbTrafficSeen);
      // in external mode the pin belongs to the resonator
      oscOutputPinOeN <= useExt;
      oscOutputPin <= cfg[`CRC_CFG_CLKOUT_DIS] ? 1'b1 : intClkSync[1];
      oscInputPullDown <= !useExt;
      // plain level, never routed to any interrupt
      auxPortBitOne <= useExt ? 1'b0 : oscInSync[1];
    end
  end

  // ----------------------------------------------------------------
  // reset outputs
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      chipRstn <= 1'b0;
      cpuHalt <= 1'b1;
      pinsHighZ <= 1'b1;
      lvrActive <= 1'b1;
      // constant targets: loaded by reset, then simply held
      resetVector <= `CRC_RESET_PC;
      resetNoPush <= 1'b1;
      stackPtrInit <= `CRC_RESET_SP;
      dataStackInit <= `CRC_RESET_SP;
    end
    else
    begin
      // chip reset clears other registers, tristates pins, masks irqs
      chipRstn <= (state != S_START) && (state != S_WDHOLD);
      pinsHighZ <= (state == S_START) || (state == S_WDHOLD);
      cpuHalt <= (state != S_RUN);
      lvrActive <= lvrArmed;
    end
  end

endmodule
`default_nettype wire

// >>> sim/crc_assertions.sv
/*
  Checker for the clock and reset block, bound to its top ports.
  Assumes the shortened sim counts and a watchdog period handed on.
*/
`timescale 1ns/1ps
`default_nettype none
module crc_assertions #(
  parameter int WATCH_CYC = 400
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic ioWr,
  // supply and oscillators
  input wire logic brownOutDetect,
  input wire logic extClkStable,
  input wire logic intOscEnable,
  input wire logic extOscEnable,
  input wire logic chipClkEnable,
  input wire logic clkUseExt,
  // pins and reset outputs
  input wire logic oscOutputPin,
  input wire logic oscInputPullDown,
  input wire logic chipRstn,
  input wire logic cpuHalt,
  input wire logic [15:0] resetVector,
  input wire logic resetNoPush,
  input wire logic [7:0] stackPtrInit,
  input wire logic [7:0] dataStackInit,
  input wire logic lvrCause,
  input wire logic wdrCause
);
  logic outDis;
  int wdCnt;
  // ----------------------------------------
  // shadow state
  // ----------------------------------------
  // the output-disable shadow drops on any chip reset, as the cfg does
  always @(posedge core_clk)
  begin
    if (!resetn || !chipRstn)
      outDis <= 1'b0;
    else if (ioWr && ioAddr == 8'hF8 && !cpuHalt)
      outDis <= ioWrData[1];
    if (!resetn || cpuHalt || (ioWr && ioAddr == 8'h26))
      wdCnt <= 0;
    else
      wdCnt <= wdCnt + 1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  vector_zero_a: assert property (resetVector == 16'h0000 && resetNoPush)
    else $error("reset vector or no-push flag wrong");
  stack_zero_a: assert property (stackPtrInit == 8'h00 && dataStackInit == 8'h00)
    else $error("stack pointer reset value wrong");
  pull_down_a: assert property (oscInputPullDown == !clkUseExt)
    else $error("input pull-down not tied to internal mode");
  ext_halt_a: assert property (ioWr && ioAddr == 8'hF8 && ioWrData[0] && !cpuHalt
    && !clkUseExt && !extOscEnable |-> ##2 (cpuHalt && extOscEnable
    && !intOscEnable && !chipClkEnable))
    else $error("external switch did not halt");
  ext_delay_a: assert property ($rose(extClkStable) && extOscEnable && cpuHalt
    |-> cpuHalt [*8] ##[1:20] !cpuHalt)
    else $error("resume delay after stable clock wrong");
  clk_out_high_a: assert property (outDis [*3] ##0 (!clkUseExt && chipRstn)
    |-> oscOutputPin)
    else $error("clock output pin not high while disabled");
  wdr_hold_a: assert property ($rose(wdrCause) |-> ##1
    (!chipRstn && $stable(clkUseExt)) [*8] ##[1:8] chipRstn)
    else $error("watchdog hold wrong");
  wd_late_a: assert property (wdCnt <= WATCH_CYC + 4)
    else $error("watchdog did not roll over");
  wd_early_a: assert property ($rose(wdrCause) |-> $past(wdCnt) >= WATCH_CYC - 4)
    else $error("watchdog rolled over early");
  brown_reset_a: assert property (brownOutDetect |-> ##[2:6]
    (!chipRstn && lvrCause && !extOscEnable))
    else $error("brown-out reset not taken");
  cover property ($rose(wdrCause));
  cover property ($fell(clkUseExt));
  cover property ($rose(extClkStable) ##[1:30] !cpuHalt);
endmodule
`default_nettype wire

// >>> sim/crc_resonator.sv
/*
  External resonator model: reports a stable clock some cycles after
  being enabled. Assumes its enable comes from the device on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module crc_resonator #(
  parameter int FAST_CYC = 6,
  parameter int SLOW_CYC = 40
)
(
  // clock
  input wire logic core_clk,
  // control
  input wire logic oscOn,
  input wire logic slowStart,
  // status
  output var logic clkStable
);
  int cnt = 0;
  initial clkStable = 1'b0;
  // a crystal settles far slower than a ceramic part
  always @(posedge core_clk)
  begin
    if (!oscOn)
    begin
      cnt <= 0;
      clkStable <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 1;
      clkStable <= cnt >= (slowStart ? SLOW_CYC : FAST_CYC);
    end
  end
endmodule
`default_nettype wire

// >>> sim/crc_clock_reset_test.sv
/*
  Testbench for the clock and reset block with a resonator model.
  Assumes shortened counts; the watchdog period is widened for room.
*/
`timescale 1ns/1ps
`default_nettype none
module crc_clock_reset_test;
  localparam int WATCH = 400;
  logic core_clk, resetn, ioWr, ioRd, lowVoltDetect, brownOutDetect;
  logic usbTrafficSeen, suspendReq, wakeEvent, oscInputPin, slowStart;
  logic [7:0] ioAddr, ioWrData, rdVal;
  logic [3:0] oscDiv = 4'h0;
  wire [7:0] ioRdData, stackPtrInit, dataStackInit;
  wire [15:0] resetVector;
  wire extClkStable, intOscEnable, extOscEnable, chipClkEnable, clkUseExt;
  wire trimEnable, precisionLocked, oscOutputPin, oscOutputPinOeN;
  wire oscInputPullDown, auxPortBitOne, chipRstn, cpuHalt, pinsHighZ;
  wire lvrActive, resetNoPush, lvrCause, wdrCause;
  wire intOscClk = oscDiv[2];
  int fails = 0, compares = 0, t1, t2, n;
  crc_clock_reset #(.EXT_SHORT_CYC(8), .EXT_LONG_CYC(16),
    .WDR_HOLD_CYC(12), .START_CYC(10), .WATCH_CYC(WATCH)) DUT (
    .core_clk, .resetn, .ioAddr, .ioWrData, .ioWr, .ioRd, .ioRdData,
    .lowVoltDetect, .brownOutDetect, .usbTrafficSeen, .suspendReq,
    .wakeEvent, .intOscClk, .extClkStable, .intOscEnable, .extOscEnable,
    .chipClkEnable, .clkUseExt, .trimEnable, .precisionLocked,
    .oscInputPin, .oscOutputPin, .oscOutputPinOeN, .oscInputPullDown,
    .auxPortBitOne, .chipRstn, .cpuHalt, .pinsHighZ, .lvrActive,
    .resetVector, .resetNoPush, .stackPtrInit, .dataStackInit,
    .lvrCause, .wdrCause);
  crc_resonator RES (.core_clk, .oscOn(extOscEnable), .slowStart,
    .clkStable(extClkStable));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim;
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    ioAddr <= a;
    ioWrData <= d;
    ioWr <= 1'b1;
    @(posedge core_clk);
    ioWr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge core_clk);
    ioAddr <= a;
    ioRd <= 1'b1;
    @(posedge core_clk);
    ioRd <= 1'b0;
    #1 rdVal = ioRdData;
  endtask
  // usb traffic, suspend and wake are one-cycle pulses
  task automatic pulseEv(logic [2:0] m);
    @(posedge core_clk);
    {usbTrafficSeen, suspendReq, wakeEvent} <= m;
    @(posedge core_clk);
    {usbTrafficSeen, suspendReq, wakeEvent} <= 3'h0;
  endtask
  task automatic waitRun(output int k);
    k = 0;
    do
    begin
      @(posedge core_clk);
      #1 k++;
    end
    while (cpuHalt !== 1'b0 && k < 300);
    if (k >= 300)
      fails++;
  endtask
  task automatic extDelay(output int k);
    k = 0;
    while (extClkStable !== 1'b1 && k < 300)
    begin
      @(posedge core_clk);
      #1 k++;
    end
    waitRun(k);
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    oscDiv <= oscDiv + 4'h1;
  initial
  begin
    cyc(20000);
    fails++;
    end_sim;
  end
  initial
  begin
    {ioWr, ioRd, lowVoltDetect, brownOutDetect, usbTrafficSeen} = 5'h00;
    {suspendReq, wakeEvent, oscInputPin, slowStart} = 4'h0;
    {ioAddr, ioWrData, resetn} = 17'h00000;
    cyc(3);
    #1 chk("chipRstn", chipRstn, 0);
    chk("pinsHighZ", pinsHighZ, 1);
    chk("intOscEnable", intOscEnable, 1);
    chk("oscOutputPinOeN", oscOutputPinOeN, 0);
    cyc(1);
    resetn <= 1'b1;
    waitRun(n);
    chk("startWait", n >= 10, 1);
    chk("lvrCause", lvrCause, 1);
    chk("clkUseExt", clkUseExt, 0);
    chk("resetVector", resetVector, 16'h0000);
    chk("stackInit", {stackPtrInit, dataStackInit}, 16'h0000);
    t1 = 0;
    repeat (8)
    begin
      @(posedge core_clk);
      #1 t1 += oscOutputPin;
    end
    chk("clkOutHigh", t1, 4);
    rd(8'hF8);
    chk("cfg", rdVal, 8'h00);
    rd(8'h10);
    chk("unmapped", rdVal, 8'h00);
    rd(8'h26);
    chk("wdClearRead", rdVal, 8'h00);
    rd(8'hFF);
    chk("psc", rdVal & 8'h50, 8'h10);
    wr(8'hFF, 8'h00);
    rd(8'hFF);
    chk("pscClear", rdVal & 8'h50, 8'h00);
    wr(8'hF8, 8'h06);
    oscInputPin <= 1'b1;
    cyc(4);
    #1 chk("trimEnable", trimEnable, 1);
    chk("precisionLocked", precisionLocked, 0);
    chk("oscOutputPin", oscOutputPin, 1);
    chk("auxPortBitOne", auxPortBitOne, 1);
    pulseEv(3'h4);
    cyc(2);
    #1 chk("precisionLocked", precisionLocked, 1);
    wr(8'h26, 8'h00);
    wr(8'hF8, 8'h05);
    cyc(2);
    #1 chk("cpuHalt", cpuHalt, 1);
    chk("chipClkEnable", chipClkEnable, 0);
    chk("intOscEnable", intOscEnable, 0);
    chk("extOscEnable", extOscEnable, 1);
    extDelay(t1);
    chk("clkUseExt", clkUseExt, 1);
    chk("chipClkEnable", chipClkEnable, 1);
    chk("oscOutputPinOeN", oscOutputPinOeN, 1);
    chk("trimEnable", trimEnable, 0);
    chk("oscInputPullDown", oscInputPullDown, 0);
    chk("auxPortBitOne", auxPortBitOne, 0);
    wr(8'hF8, 8'h00);
    cyc(3);
    #1 chk("clkUseExt", clkUseExt, 1);
    pulseEv(3'h2);
    cyc(5);
    pulseEv(3'h1);
    waitRun(n);
    chk("clkUseExt", clkUseExt, 0);
    slowStart = 1'b1;
    wr(8'h26, 8'h00);
    wr(8'hF8, 8'h81);
    extDelay(t2);
    chk("resumeDelay", t2 - t1, 8);
    repeat (3)
    begin
      cyc(WATCH - 100);
      wr(8'h26, 8'h5A);
    end
    chk("wdrCause", wdrCause, 0);
    n = 0;
    while (wdrCause !== 1'b1 && n < 600)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("wdrCause", wdrCause, 1);
    waitRun(n);
    chk("wdrHold", n >= 12, 1);
    chk("clkUseExt", clkUseExt, 1);
    rd(8'hF8);
    chk("cfgAfterWdr", rdVal, 8'h00);
    rd(8'hFF);
    chk("pscWdr", rdVal & 8'h40, 8'h40);
    @(posedge core_clk);
    brownOutDetect <= 1'b1;
    cyc(3);
    brownOutDetect <= 1'b0;
    waitRun(n);
    chk("clkUseExt", clkUseExt, 0);
    chk("extOscEnable", extOscEnable, 0);
    chk("lvrCause", lvrCause, 1);
    chk("lvrActive", lvrActive, 1);
    wr(8'hF8, 8'h08);
    lowVoltDetect <= 1'b1;
    cyc(10);
    #1 chk("chipRstn", chipRstn, 1);
    chk("lvrActive", lvrActive, 0);
    @(posedge core_clk);
    lowVoltDetect <= 1'b0;
    wr(8'hF8, 8'h00);
    lowVoltDetect <= 1'b1;
    cyc(30);
    #1 chk("chipRstn", chipRstn, 0);
    @(posedge core_clk);
    lowVoltDetect <= 1'b0;
    waitRun(n);
    chk("startAgain", n >= 10, 1);
    end_sim;
  end
endmodule
bind crc_clock_reset crc_assertions #(.WATCH_CYC(WATCH_CYC)) CHK (
  .core_clk, .resetn, .ioAddr, .ioWrData, .ioWr, .brownOutDetect,
  .extClkStable, .intOscEnable, .extOscEnable, .chipClkEnable,
  .clkUseExt, .oscOutputPin, .oscInputPullDown, .chipRstn, .cpuHalt,
  .resetVector, .resetNoPush, .stackPtrInit, .dataStackInit,
  .lvrCause, .wdrCause);
`default_nettype wire
